/* File: ddr3_mode_map.svh */
// Offsets, field positions, reset values and last beat indices of the DDR3 mode block
// Assumes inclusion by bare name from the core module
`ifndef DDR3_MODE_MAP_SVH
`define DDR3_MODE_MAP_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define OFF_STATUS     8'h00
`define OFF_DLLK       8'h04
`define OFF_MR0        8'h10
`define OFF_MR1        8'h14
`define OFF_MR2        8'h18
`define OFF_MR3        8'h1C

// ----------------------------------------------------------------------
// Status field positions
// ----------------------------------------------------------------------
`define ST_IN_RESET    0
`define ST_CKE_SEEN    1
`define ST_MR_VALID    2
`define ST_DLL_LOCKED  6
`define ST_ZQ_SEEN     7

// ----------------------------------------------------------------------
// Mode register 0 fields and pin positions
// ----------------------------------------------------------------------
`define MR0_BL_LSB     0
`define MR0_BT_BIT     3
`define MR0_DLLRST_BIT 8
`define ADDR_AP_BIT    10
`define ADDR_BC_BIT    12

// ----------------------------------------------------------------------
// Burst length codes, reset value and last beat indices
// ----------------------------------------------------------------------
`define BL_FIXED8      2'h0
`define BL_OTF         2'h1
`define BL_CHOP4       2'h2
`define DLLK_RST       16'h0200
`define BEATS_LAST     3'h7
`define BEATS_CHOP     3'h3

`endif

/* File: ddr3_mode_pkg.sv */
// Types shared by the DDR3 mode block
// Assumes the map header sits in the same folder
package ddr3_mode_pkg;

   // Command and address pins sampled together
   typedef struct packed {
      logic        cs_n;
      logic        ras_n;
      logic        cas_n;
      logic        we_n;
      logic [2:0]  ba;
      logic [13:0] addr;
   } pin_cmd_s;

   // Decoded link commands
   typedef enum logic [2:0] {
      CMD_NOP   = 3'b000,
      CMD_MRS   = 3'b001,
      CMD_READ  = 3'b010,
      CMD_WRITE = 3'b011,
      CMD_ZQCL  = 3'b100,
      CMD_OTHER = 3'b101
   } cmd_e;

   // Burst engine states
   typedef enum logic {
      BST_IDLE = 1'b0,
      BST_RUN  = 1'b1
   } burst_e;

   // One beat as handed to the data path
   typedef struct packed {
      logic       valid;
      logic       write;
      logic       use_beat;
      logic [2:0] col;
   } beat_s;

endpackage

/* File: mode_reg_mem.sv */
// Small storage for the four mode registers, registered read data
// Assumes one clock, one write port and one read port
`timescale 1ns/10ps
module mode_reg_mem #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 4,
   parameter int AW    = 2
) (
   // Clock
   input  wire logic             clk,
   // Write port
   input  wire logic             we,
   input  wire logic [AW-1:0]    waddr,
   input  wire logic [WIDTH-1:0] wdata,
   // Read port
   input  wire logic             re,
   input  wire logic [AW-1:0]    raddr,
   output      logic [WIDTH-1:0] rdata
);

   logic [WIDTH-1:0] mem [DEPTH];

   // Write and registered read
   always_ff @(posedge clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
      if (re) begin
         rdata <= mem[raddr];
      end
   end

endmodule

/* File: ddr3_mode_core.sv */
// Device-side DDR3 mode register, init tracking and burst order logic
// Assumes pins from the controller are asynchronous to REF_CLK, CK is slow
// enough to sample, and an AHB-Lite master owns the register bus
`timescale 1ns/10ps
`include "ddr3_mode_map.svh"

// Behaviour
// - Termination stays off in reset and until CKE is registered high.
// - Mode registers start undefined and must all be written after reset.
// - MRS and DLL reset never touch array contents.
// - Burst type from MR0 A3, burst length from A1:A0 or on the fly.
// - Length-8 reads wrap within group of four, or XOR for interleave.
// - Chop-4 reads give four ordered beats; chop-4 writes use column bit 2.
// - The DLL reset bit is stored cleared by the same MRS write that requests the DLL reset.
module ddr3_mode_core
   import ddr3_mode_pkg::*;
(
   // Clock and reset
   input  wire logic        REF_CLK,
   input  wire logic        NRST,
   // AHB-Lite slave
   input  wire logic        HSEL,
   input  wire logic [31:0] HADDR,
   input  wire logic [1:0]  HTRANS,
   input  wire logic        HWRITE,
   input  wire logic [2:0]  HSIZE,
   input  wire logic        HREADY,
   input  wire logic [31:0] HWDATA,
   output      logic        HREADYOUT,
   output      logic        HRESP,
   output      logic [31:0] HRDATA,
   // Memory pins from the controller
   input  wire logic        CK,
   input  wire logic        RESET_N,
   input  wire logic        CKE,
   input  wire logic        ODT,
   input  wire pin_cmd_s    CMD_PINS,
   // Termination and DLL state
   output      logic        TERM_EN,
   output      logic        DLL_LOCKED,
   // Burst beats toward the data path
   output      logic        BEAT_VALID,
   output      logic        BEAT_WRITE,
   output      logic        BEAT_USE,
   output      logic [2:0]  BEAT_COL
);

   // ----------------------------------------------------------------------
   // Pin synchronisers and CK edge detection
   // ----------------------------------------------------------------------
   localparam int PW = $bits(pin_cmd_s) + 4;

   logic [PW-1:0] sync1_r;
   logic [PW-1:0] sync2_r;
   logic          ck_d_r;
   pin_cmd_s      cmd_s2;
   wire           ck_s2    = sync2_r[PW-1];
   wire           rst_n_s2 = sync2_r[PW-2];
   wire           cke_s2   = sync2_r[PW-3];
   wire           odt_s2   = sync2_r[PW-4];
   wire           ck_rise  = ck_s2 & ~ck_d_r;
   assign cmd_s2 = sync2_r[$bits(pin_cmd_s)-1:0];

   // Two stages on every pin, third flop on CK only for the edge
   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         sync1_r <= '0;
         sync2_r <= '0;
         ck_d_r  <= 1'b0;
      end else begin
         sync1_r <= {CK, RESET_N, CKE, ODT, CMD_PINS};
         sync2_r <= sync1_r;
         ck_d_r  <= ck_s2;
      end
   end

   // ----------------------------------------------------------------------
   // Command decode
   // ----------------------------------------------------------------------
   logic [3:0] ctl;
   cmd_e       cmd;
   wire        take  = ck_rise & rst_n_s2 & cke_s2;
   assign ctl = {cmd_s2.cs_n, cmd_s2.ras_n, cmd_s2.cas_n, cmd_s2.we_n};
   assign cmd = (ctl[3])             ? CMD_NOP   :
                (ctl[2:0] == 3'b000) ? CMD_MRS   :
                (ctl[2:0] == 3'b101) ? CMD_READ  :
                (ctl[2:0] == 3'b100) ? CMD_WRITE :
                (ctl[2:0] == 3'b110) ? CMD_ZQCL  :
                (ctl[2:0] == 3'b111) ? CMD_NOP   : CMD_OTHER;
   wire        do_mrs  = take & (cmd == CMD_MRS);
   wire        do_rd   = take & (cmd == CMD_READ);
   wire        do_wr   = take & (cmd == CMD_WRITE);
   wire        do_zqcl = take & (cmd == CMD_ZQCL) & cmd_s2.addr[`ADDR_AP_BIT];
   wire        mrs_mr0 = do_mrs & (cmd_s2.ba[1:0] == 2'h0);
   wire        dll_req = mrs_mr0 & cmd_s2.addr[`MR0_DLLRST_BIT];

   // ----------------------------------------------------------------------
   // Init tracking, termination and DLL
   // ----------------------------------------------------------------------
   logic        cke_seen_r;
   logic        zq_seen_r;
   logic [3:0]  mr_valid_r;
   logic [15:0] dllk_r;
   logic [15:0] dll_cnt_r;
   logic [1:0]  mr0_bl_r;
   logic        mr0_bt_r;

   // Reset pin clears init state; mode contents are not trusted again
   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         cke_seen_r <= 1'b0;
         zq_seen_r  <= 1'b0;
         mr_valid_r <= 4'h0;
         dll_cnt_r  <= 16'h0000;
         TERM_EN    <= 1'b0;
         DLL_LOCKED <= 1'b0;
      end else if (!rst_n_s2) begin
         cke_seen_r <= 1'b0;
         zq_seen_r  <= 1'b0;
         mr_valid_r <= 4'h0;
         dll_cnt_r  <= 16'h0000;
         TERM_EN    <= 1'b0;
         DLL_LOCKED <= 1'b0;
      end else begin
         if (ck_rise && cke_s2) begin
            cke_seen_r <= 1'b1;
         end
         if (do_zqcl) begin
            zq_seen_r <= 1'b1;
         end
         if (do_mrs) begin
            mr_valid_r[cmd_s2.ba[1:0]] <= 1'b1;
         end
         if (dll_req) begin
            dll_cnt_r  <= dllk_r;
            DLL_LOCKED <= 1'b0;
         end else if (ck_rise && dll_cnt_r != 16'h0000) begin
            dll_cnt_r <= dll_cnt_r - 16'h0001;
            DLL_LOCKED <= (dll_cnt_r == 16'h0001);
         end
         TERM_EN <= cke_seen_r & odt_s2;
      end
   end

   // Burst fields of MR0 kept beside the memory for the beat engine
   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         mr0_bl_r <= `BL_FIXED8;
         mr0_bt_r <= 1'b0;
      end else if (mrs_mr0) begin
         mr0_bl_r <= cmd_s2.addr[`MR0_BL_LSB +: 2];
         mr0_bt_r <= cmd_s2.addr[`MR0_BT_BIT];
      end
   end

   // ----------------------------------------------------------------------
   // Mode register storage
   // ----------------------------------------------------------------------
   logic [15:0] mem_rdata;
   logic [15:0] mr_wdata;
   logic        ap_take;
   logic        ap_mr;
   // DLL reset bit stored as cleared: it has been acted on already
   assign mr_wdata = {2'b00, cmd_s2.addr} &
                     ~(16'(mrs_mr0) << `MR0_DLLRST_BIT);

   // Array contents live elsewhere; only these words change on MRS
   mode_reg_mem #(
      .WIDTH (16),
      .DEPTH (4),
      .AW    (2)
   ) u_mem (
      .clk   (REF_CLK),
      .we    (do_mrs),
      .waddr (cmd_s2.ba[1:0]),
      .wdata (mr_wdata),
      .re    (ap_take & ap_mr),
      .raddr (HADDR[3:2]),
      .rdata (mem_rdata)
   );

   // ----------------------------------------------------------------------
   // Burst order engine
   // ----------------------------------------------------------------------
   burst_e     bst_r;
   logic [2:0] idx_r;
   logic [2:0] start_r;
   logic       chop_r;
   logic       bwr_r;
   logic       bt_r;
   wire        otf_chop = (mr0_bl_r == `BL_OTF) & ~cmd_s2.addr[`ADDR_BC_BIT];
   wire        new_chop = (mr0_bl_r == `BL_CHOP4) | otf_chop;
   wire [2:0]  wr_start = new_chop ? {cmd_s2.addr[2], 2'b00} : 3'h0;
   wire [2:0]  new_start = do_wr ? wr_start : cmd_s2.addr[2:0];
   wire [1:0]  seq_lo   = start_r[1:0] + idx_r[1:0];
   wire [2:0]  seq_col  = {start_r[2] ^ idx_r[2], seq_lo};
   wire [2:0]  int_col  = start_r ^ idx_r;
   wire [2:0]  beat_col = bt_r ? int_col : seq_col;
   wire [2:0]  last_idx = `BEATS_LAST;
   wire        in_chop  = ~chop_r | (idx_r <= `BEATS_CHOP);

   // Eight beats per command; chop tail marked unused
   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         bst_r   <= BST_IDLE;
         idx_r   <= 3'h0;
         start_r <= 3'h0;
         chop_r  <= 1'b0;
         bwr_r   <= 1'b0;
         bt_r    <= 1'b0;
      end else begin
         unique case (bst_r)
            BST_IDLE: begin
               if (do_rd || do_wr) begin
                  bst_r   <= BST_RUN;
                  idx_r   <= 3'h0;
                  start_r <= new_start;
                  chop_r  <= new_chop;
                  bwr_r   <= do_wr;
                  bt_r    <= mr0_bt_r & do_rd;
               end
            end
            BST_RUN: begin
               idx_r <= idx_r + 3'h1;
               if (idx_r == last_idx) begin
                  bst_r <= BST_IDLE;
               end
            end
         endcase
      end
   end

   // Registered beat outputs
   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         BEAT_VALID <= 1'b0;
         BEAT_WRITE <= 1'b0;
         BEAT_USE   <= 1'b0;
         BEAT_COL   <= 3'h0;
      end else begin
         BEAT_VALID <= (bst_r == BST_RUN);
         BEAT_WRITE <= bwr_r;
         BEAT_USE   <= (bst_r == BST_RUN) & in_chop;
         BEAT_COL   <= beat_col;
      end
   end

   // ----------------------------------------------------------------------
   // AHB-Lite register slave
   // ----------------------------------------------------------------------
   logic        dp_wr_r;
   logic [7:0]  dp_off_r;
   logic        rd_wait_r;
   logic [31:0] status;
   logic [31:0] rd_mux;
   wire         hi_zero = (HADDR[31:8] == 24'h000000);
   assign ap_take = HSEL & HTRANS[1] & HREADY;
   assign ap_mr   = hi_zero & (HADDR[7:4] == 4'h1) & (HADDR[1:0] == 2'h0);
   assign status  = {24'h000000, zq_seen_r, DLL_LOCKED, mr_valid_r,
                     cke_seen_r, ~rst_n_s2};
   assign rd_mux  = (!hi_zero)                  ? 32'h00000000 :
                    (HADDR[7:0] == `OFF_STATUS) ? status :
                    (HADDR[7:0] == `OFF_DLLK)   ? {16'h0000, dllk_r} :
                                                  32'h00000000;

   // Address phase capture, read data and the one wait on mode reads
   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         dp_wr_r   <= 1'b0;
         dp_off_r  <= 8'h00;
         rd_wait_r <= 1'b0;
         HREADYOUT <= 1'b1;
         HRESP     <= 1'b0;
         HRDATA    <= 32'h00000000;
      end else begin
         HRESP <= 1'b0;
         if (rd_wait_r) begin
            rd_wait_r <= 1'b0;
            HREADYOUT <= 1'b1;
            HRDATA    <= {16'h0000, mem_rdata};
         end else if (ap_take) begin
            dp_wr_r  <= HWRITE & hi_zero;
            dp_off_r <= HADDR[7:0];
            if (!HWRITE && ap_mr) begin
               rd_wait_r <= 1'b1;
               HREADYOUT <= 1'b0;
            end else if (!HWRITE) begin
               HRDATA <= rd_mux;
            end
         end else begin
            dp_wr_r <= 1'b0;
         end
      end
   end

   // Data phase write of the DLL lock count
   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         dllk_r <= `DLLK_RST;
      end else if (dp_wr_r && dp_off_r == `OFF_DLLK) begin
         dllk_r <= HWDATA[15:0];
      end
   end

endmodule

/* File: ddr3_mode_monitor.sv */
// Checker for the DDR3 mode block, sees only the core's ports
// Assumes it is bound into ddr3_mode_core by the testbench
`timescale 1ns/10ps
module ddr3_mode_monitor
   import ddr3_mode_pkg::*;
(
   // Clock and reset
   input wire logic       REF_CLK,
   input wire logic       NRST,
   // Observed pins
   input wire logic       RESET_N,
   input wire logic       TERM_EN,
   input wire logic       DLL_LOCKED,
   input wire logic       BEAT_VALID,
   input wire logic       BEAT_WRITE,
   input wire logic       BEAT_USE,
   input wire logic [2:0] BEAT_COL
);
   // -----------------------------------------------------------
   // Termination, DLL and burst relations
   // -----------------------------------------------------------
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (!NRST);
   property p_term_rst; !RESET_N [*5] |-> !TERM_EN; endproperty
   a_term_rst: assert property (p_term_rst) else $error("termination on in reset");
   property p_dll_rst; !RESET_N [*5] |-> !DLL_LOCKED; endproperty
   a_dll_rst: assert property (p_dll_rst) else $error("lock kept over reset");
   property p_len8; $rose(BEAT_VALID) |-> BEAT_VALID [*8] ##1 !BEAT_VALID; endproperty
   a_len8: assert property (p_len8) else $error("burst not eight beats");
   property p_first; $rose(BEAT_VALID) |-> BEAT_USE; endproperty
   a_first: assert property (p_first) else $error("first beat unused");
   property p_tail; BEAT_VALID && !BEAT_USE ##1 BEAT_VALID |-> !BEAT_USE; endproperty
   a_tail: assert property (p_tail) else $error("chop tail reused");
   property p_wr_inc;
      BEAT_VALID && BEAT_WRITE && BEAT_USE ##1 BEAT_VALID && BEAT_USE
         |-> BEAT_COL == $past(BEAT_COL) + 3'h1;
   endproperty
   a_wr_inc: assert property (p_wr_inc) else $error("write column skipped");
   property p_wr_align; $rose(BEAT_VALID) && BEAT_WRITE |-> BEAT_COL[1:0] == 2'h0; endproperty
   a_wr_align: assert property (p_wr_align) else $error("write start unaligned");
   property p_half;
      $rose(BEAT_VALID) |-> ##4 (!BEAT_USE || BEAT_COL[2] != $past(BEAT_COL[2], 4));
   endproperty
   a_half: assert property (p_half) else $error("second group not flipped");
endmodule

/* File: ddr3_ctl_model.sv */
// Behavioural DDR3 controller driving the memory pins of the mode block
// Assumes the testbench calls its tasks and wires its outputs to the core
`timescale 1ns/10ps
module ddr3_ctl_model
   import ddr3_mode_pkg::*;
(
   // Memory clock and control
   output logic     ck,
   output logic     reset_n,
   output logic     cke,
   output logic     odt,
   // Command and address
   output pin_cmd_s pins
);
   // Free-running memory clock, phase unrelated to the block clock
   initial begin
      ck = 1'b0;
      reset_n = 1'b0;
      cke = 1'b0;
      odt = 1'b1;
      pins = '1;
      #7;
      forever #80 ck = ~ck;
   end
   // One command for one CK rise, then deselect with flipped lines
   task automatic issue(input logic [3:0] c, input logic [2:0] ba, input logic [13:0] a);
      @(negedge ck);
      pins <= {c, ba, a};
      @(negedge ck);
      pins <= {1'b1, ~pins[19:0]};
      repeat (2) @(negedge ck);
   endtask
   // ODT level change on a CK fall
   task automatic set_odt(input logic v);
      @(negedge ck);
      odt <= v;
   endtask
   // Reset with stable power, then the mode register sequence
   task automatic init(input logic [13:0] m0, m1, m2, m3);
      cke <= 1'b0;
      odt <= 1'b1;
      reset_n <= 1'b0;
      #200;
      reset_n <= 1'b1;
      @(negedge ck);
      odt <= 1'b0;
      @(negedge ck);
      cke <= 1'b1;
      repeat (6) @(negedge ck);
      issue(4'h0, 3'b010, m2);
      issue(4'h0, 3'b011, m3);
      issue(4'h0, 3'b001, m1 & 14'h1FFE);
      issue(4'h0, 3'b000, (m0 & 14'h1FFF) | 14'h0100);
      issue(4'h6, 3'b000, 14'h0400);
   endtask
endmodule

/* File: tb.sv */
// Self-checking bench for the DDR3 mode block
// Assumes core, controller model and monitor are compiled first
`timescale 1ns/10ps
module tb
   import ddr3_mode_pkg::*;
;
   logic        REF_CLK = 1'b0;
   logic        NRST = 1'b0;
   logic        HSEL = 1'b0;
   logic [31:0] HADDR = '0;
   logic [1:0]  HTRANS = '0;
   logic        HWRITE = 1'b0;
   logic [31:0] HWDATA = '0;
   logic        HREADYOUT, HRESP, TERM_EN, DLL_LOCKED;
   logic        CK, RESET_N, CKE, ODT, BEAT_VALID, BEAT_WRITE, BEAT_USE;
   logic [31:0] HRDATA;
   logic [2:0]  BEAT_COL;
   pin_cmd_s    CMD_PINS;
   int          n_mismatch = 0;
   int          compares = 0;
   logic [31:0] rd_q[$];
   logic [4:0]  bt_q[$];
   logic [4:0]  e;
   logic        rd_pend = 1'b0;
   logic [31:0] seed = 32'h0001_2287;

   always #10 REF_CLK = ~REF_CLK;

   ddr3_mode_core uut (.REF_CLK(REF_CLK), .NRST(NRST), .HSEL(HSEL), .HADDR(HADDR),
      .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'h2), .HREADY(HREADYOUT),
      .HWDATA(HWDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .HRDATA(HRDATA),
      .CK(CK), .RESET_N(RESET_N), .CKE(CKE), .ODT(ODT), .CMD_PINS(CMD_PINS),
      .TERM_EN(TERM_EN), .DLL_LOCKED(DLL_LOCKED), .BEAT_VALID(BEAT_VALID),
      .BEAT_WRITE(BEAT_WRITE), .BEAT_USE(BEAT_USE), .BEAT_COL(BEAT_COL));
   ddr3_ctl_model ctl (.ck(CK), .reset_n(RESET_N), .cke(CKE), .odt(ODT), .pins(CMD_PINS));

   // -----------------------------------------------------------
   // Helpers
   // -----------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic close_out;
      if (n_mismatch == 0 && compares > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // Expected beat {write, use, column}
   function automatic logic [4:0] beat(input logic w, ch, il, input logic [2:0] s, i);
      if (ch && i[2])
         return {w, 4'h0};
      if (w)
         return {2'b11, ch ? {s[2], i[1:0]} : i};
      return {2'b01, il ? s ^ i : {s[2] ^ i[2], s[1:0] + i[1:0]}};
   endfunction
   // Bounded wait: 0 ready, 1 lock, 2 termination
   task automatic wait_hi(input int k);
      int n;
      n = 0;
      do begin
         @(posedge REF_CLK);
         n++;
      end while ((k == 0 ? HREADYOUT : k == 1 ? DLL_LOCKED : TERM_EN) !== 1'b1 && n < 500);
      if (n >= 500) begin
         n_mismatch++;
         $display("ERROR %0t: wait timed out", $time);
         close_out();
      end
   endtask
   // One AHB-Lite single transfer, read expectation queued
   task automatic bus(input logic w, input logic [31:0] a, d, exp);
      HSEL <= 1'b1;
      HTRANS <= 2'h2;
      HWRITE <= w;
      HADDR <= a;
      if (!w)
         rd_q.push_back(exp);
      wait_hi(0);
      HSEL <= 1'b0;
      HTRANS <= 2'h0;
      HWDATA <= d;
      wait_hi(0);
   endtask

   // Output watcher: read data and burst beats against queued notes
   always @(posedge REF_CLK) begin
      if (rd_pend && HREADYOUT === 1'b1) begin
         check(HRDATA, rd_q.pop_front());
         check(HRESP, 0);
      end
      if (HREADYOUT === 1'b1)
         rd_pend <= HSEL && HTRANS[1] && !HWRITE;
      // A beat with no note queued is always a mismatch
      if (BEAT_VALID === 1'b1 && bt_q.size() == 0) begin
         check(BEAT_VALID, 0);
      end else if (BEAT_VALID === 1'b1) begin
         e = bt_q.pop_front();
         check({BEAT_WRITE, BEAT_USE, e[3] ? BEAT_COL : 3'h0}, e);
      end
   end

   // Main sequence
   initial begin
      logic [31:0] v [4];
      logic [31:0] r;
      logic        ch;
      repeat (5) @(posedge REF_CLK);
      NRST <= 1'b1;
      @(posedge REF_CLK);
      bus(1, 32'h04, 32'h4, 0);
      bus(0, 32'h04, 0, 32'h4);
      bus(1, 32'h40, 32'h5A5A, 0);
      bus(0, 32'h40, 0, 0);
      for (int k = 0; k < 2; k++) begin
         for (int j = 0; j < 4; j++)
            v[j] = rnd() & 32'h1FFF;
         ctl.init(v[0][13:0], v[1][13:0], v[2][13:0], v[3][13:0]);
         wait_hi(1);
         check(TERM_EN, 0);
         bus(0, 32'h00, 0, 32'hFE);
         bus(0, 32'h10, 0, v[0] & 32'h1EFF);
         bus(0, 32'h14, 0, v[1] & 32'h1FFE);
         bus(0, 32'h18, 0, v[2]);
         bus(0, 32'h1C, 0, v[3]);
      end
      ctl.set_odt(1'b1);
      wait_hi(2);
      check(TERM_EN, 1);
      ctl.set_odt(1'b0);
      for (int m = 0; m < 6; m++) begin
         ctl.issue(4'h0, 3'b000, {10'h000, m >= 3, 1'b0, 2'(m % 3 == 1 ? 2 : m % 3 == 2)});
         for (int w = 0; w < 2; w++) begin
            r = rnd();
            ch = (m % 3 == 1) || (m % 3 == 2 && !r[12]);
            for (int i = 0; i < 8; i++)
               bt_q.push_back(beat(w[0], ch, m >= 3, r[2:0], 3'(i)));
            ctl.issue(w ? 4'h4 : 4'h5, 3'h0, {1'b0, r[12], 9'h000, r[2:0]});
         end
      end
      repeat (40) @(posedge REF_CLK);
      check(32'(bt_q.size() + rd_q.size()), 0);
      close_out();
   end
endmodule

bind ddr3_mode_core ddr3_mode_monitor mon (.REF_CLK(REF_CLK), .NRST(NRST), .RESET_N(RESET_N),
   .TERM_EN(TERM_EN), .DLL_LOCKED(DLL_LOCKED), .BEAT_VALID(BEAT_VALID),
   .BEAT_WRITE(BEAT_WRITE), .BEAT_USE(BEAT_USE), .BEAT_COL(BEAT_COL));
